// *** serial_flash_bus_pkg.sv ***
// Constants, types and helpers of the serial flash bus port.
// Assumes one consumer: the serial_flash_bus_port module.
package serial_flash_bus_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL   = 2'h1,
    LANE_QUAD   = 2'h2
  } lane_mode_t;

  typedef enum logic [1:0] {
    ERASE_SECTOR  = 2'h0,
    ERASE_BLOCK32 = 2'h1,
    ERASE_BLOCK64 = 2'h2,
    ERASE_CHIP    = 2'h3
  } erase_kind_t;

  localparam int unsigned ADDR_W      = 20;
  localparam int unsigned PAGE_COUNT  = 4096;
  localparam int unsigned PAGE_BYTES  = 256;
  localparam int unsigned SECTOR_LSB  = 12;
  localparam int unsigned BLOCK32_LSB = 15;
  localparam int unsigned BLOCK64_LSB = 16;

  localparam logic [7:0] IDLE_BYTE        = 8'hFF;
  localparam logic [2:0] LAST_EDGE_SINGLE = 3'h7;
  localparam logic [2:0] LAST_EDGE_DUAL   = 3'h3;
  localparam logic [2:0] LAST_EDGE_QUAD   = 3'h1;
  localparam logic [3:0] OE_SINGLE        = 4'h2;
  localparam logic [3:0] OE_DUAL          = 4'h3;
  localparam logic [3:0] OE_QUAD          = 4'hF;
  localparam logic [9:0] CNT_MAX          = 10'h3FF;

  // Sync vector layouts, link side and system side
  localparam int unsigned LS_MODE  = 0;
  localparam int unsigned LS_QUAD  = 2;
  localparam int unsigned LS_OUTEN = 3;
  localparam int unsigned LS_TXREQ = 4;
  localparam int unsigned SY_CS    = 0;
  localparam int unsigned SY_PAUSE = 1;
  localparam int unsigned SY_WP    = 2;
  localparam int unsigned SY_RXT   = 3;
  localparam int unsigned SY_TXA   = 4;
  // Select resets low, so only a seen high then low opens the first frame
  localparam logic [4:0]  SY_IDLE  = 5'h06;

  function automatic logic [2:0] last_edge(input lane_mode_t m);
    case (m)
      LANE_DUAL: last_edge = LAST_EDGE_DUAL;
      LANE_QUAD: last_edge = LAST_EDGE_QUAD;
      default:   last_edge = LAST_EDGE_SINGLE;
    endcase
  endfunction : last_edge

endpackage : serial_flash_bus_pkg

// *** serial_flash_bus_port.sv ***
// Serial flash bus front end: pins on the serial clock, user side on
// the system clock. Assumes the host drives clock and chip select.

`timescale 1ns/1ps
`default_nettype none

module serial_flash_bus_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_spi_clk,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_lane,
  output logic      [3:0]  o_lane,
  output logic      [3:0]  o_lane_oe,
  input  wire logic        i_quad_io_enable_bit,
  input  wire logic [1:0]  i_lane_mode,
  input  wire logic        i_out_en,
  input  wire logic        i_busy,
  input  wire logic [1:0]  i_status_lock_bits,
  input  wire logic [2:0]  i_region_protect,
  input  wire logic        i_program_mode,
  input  wire logic [3:0]  i_hdr_bytes,
  input  wire logic [1:0]  i_erase_kind,
  input  wire logic [19:0] i_erase_addr,
  output logic      [19:0] o_erase_base,
  input  wire logic [7:0]  i_tx_data,
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  output logic      [7:0]  o_rx_data,
  output logic             o_rx_first,
  output logic             o_rx_valid,
  input  wire logic        i_rx_ready,
  output logic             o_selected,
  output logic             o_standby,
  output logic             o_paused,
  output logic             o_mode_refused,
  output logic             o_status_write_block,
  output logic             o_array_hw_protect,
  output logic             o_page_overflow,
  output logic             o_rx_overrun
);

  typedef enum logic [1:0] {
    ST_WAIT   = 2'h0,
    ST_IDLE   = 2'h1,
    ST_FRAME  = 2'h3,
    ST_PAUSED = 2'h2
  } st_t;

  //--------------------------------------------------------------
  // Link domain: configuration crossing
  //--------------------------------------------------------------
  logic [4:0] ls1, ls2, ls3, lf, next_lf;
  logic [7:0] tx_hold;
  logic       tx_req;
  serial_flash_bus_pkg::lane_mode_t lf_mode, eff_mode;
  logic       link_pause;

  // Change counts once stages two and three agree
  assign next_lf = (ls2 & ls3) | (lf & (ls2 ^ ls3));
  assign lf_mode = serial_flash_bus_pkg::lane_mode_t'(
                     lf[serial_flash_bus_pkg::LS_MODE +: 2]);
  // Quad falls back to single unless enabled
  assign eff_mode =
    ((lf_mode == serial_flash_bus_pkg::LANE_QUAD &&
      !lf[serial_flash_bus_pkg::LS_QUAD]) ||
     (lf_mode != serial_flash_bus_pkg::LANE_DUAL &&
      lf_mode != serial_flash_bus_pkg::LANE_QUAD)) ?
    serial_flash_bus_pkg::LANE_SINGLE : lf_mode;
  // Host keeps the clock low at pause edges, so edge sampling is safe
  assign link_pause = !lf[serial_flash_bus_pkg::LS_QUAD] &&
                      !i_lane[3];

  always_ff @(posedge i_spi_clk or posedge i_rst) begin
    if (i_rst) begin
      ls1 <= '0;
      ls2 <= '0;
      ls3 <= '0;
      lf  <= '0;
    end else begin
      ls1 <= {tx_req, i_out_en, i_quad_io_enable_bit, i_lane_mode};
      ls2 <= ls1;
      ls3 <= ls2;
      lf  <= next_lf;
    end
  end

  //--------------------------------------------------------------
  // Link domain: rising edge input shifter
  //--------------------------------------------------------------
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_shift, next_rx_shift, rx_hold, next_rx_hold;
  logic       got_edge, next_got_edge, rx_tgl, next_rx_tgl;

  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_rx_shift = rx_shift;
    next_got_edge = got_edge;
    next_rx_hold  = rx_hold;
    next_rx_tgl   = rx_tgl;
    if (!link_pause) begin
      next_got_edge = 1'b1;
      case (eff_mode)
        serial_flash_bus_pkg::LANE_DUAL:
          next_rx_shift = {rx_shift[5:0], i_lane[1:0]};
        serial_flash_bus_pkg::LANE_QUAD:
          next_rx_shift = {rx_shift[3:0], i_lane};
        default:
          next_rx_shift = {rx_shift[6:0], i_lane[0]};
      endcase
      if (bit_cnt == serial_flash_bus_pkg::last_edge(eff_mode)) begin
        next_bit_cnt = '0;
        next_rx_hold = next_rx_shift;
        next_rx_tgl  = ~rx_tgl;
      end else begin
        next_bit_cnt = bit_cnt + 3'h1;
      end
    end
  end

  // Deselect clears the lane logic, also while paused; reset too, so
  // the count is defined before the first select
  always_ff @(posedge i_spi_clk or posedge i_cs_n or posedge i_rst) begin
    if (i_cs_n || i_rst) begin
      bit_cnt  <= '0;
      rx_shift <= '0;
      got_edge <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      got_edge <= next_got_edge;
    end
  end

  // Toggle survives deselect so no false byte event appears
  always_ff @(posedge i_spi_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_hold <= '0;
      rx_tgl  <= 1'b0;
    end else begin
      rx_hold <= next_rx_hold;
      rx_tgl  <= next_rx_tgl;
    end
  end

  //--------------------------------------------------------------
  // Link domain: falling edge output shifter
  //--------------------------------------------------------------
  logic [7:0] tx_shift, next_tx_shift;
  logic [3:0] next_lane, next_lane_oe;
  logic       tx_ack, next_tx_ack;

  always_comb begin
    next_tx_shift = tx_shift;
    next_tx_ack   = tx_ack;
    next_lane_oe  = '0;
    // Mode 3 opens on a falling edge; got_edge keeps it from loading
    if (!link_pause) begin
      if (bit_cnt == '0 && got_edge) begin
        if (lf[serial_flash_bus_pkg::LS_TXREQ] != tx_ack) begin
          next_tx_shift = tx_hold;
          next_tx_ack   = ~tx_ack;
        end else begin
          next_tx_shift = serial_flash_bus_pkg::IDLE_BYTE;
        end
      end else begin
        case (eff_mode)
          serial_flash_bus_pkg::LANE_DUAL:
            next_tx_shift = {tx_shift[5:0], 2'h0};
          serial_flash_bus_pkg::LANE_QUAD:
            next_tx_shift = {tx_shift[3:0], 4'h0};
          default:
            next_tx_shift = {tx_shift[6:0], 1'b0};
        endcase
      end
    end
    case (eff_mode)
      serial_flash_bus_pkg::LANE_DUAL: begin
        next_lane = {2'h0, next_tx_shift[7:6]};
        next_lane_oe = serial_flash_bus_pkg::OE_DUAL;
      end
      serial_flash_bus_pkg::LANE_QUAD: begin
        next_lane = next_tx_shift[7:4];
        next_lane_oe = serial_flash_bus_pkg::OE_QUAD;
      end
      default: begin
        next_lane = {2'h0, next_tx_shift[7], 1'b0};
        next_lane_oe = serial_flash_bus_pkg::OE_SINGLE;
      end
    endcase
    if (!lf[serial_flash_bus_pkg::LS_OUTEN] || link_pause) begin
      next_lane_oe = '0;
    end
  end

  always_ff @(negedge i_spi_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      tx_shift  <= serial_flash_bus_pkg::IDLE_BYTE;
      o_lane    <= '0;
      o_lane_oe <= '0;
    end else begin
      tx_shift  <= next_tx_shift;
      o_lane    <= next_lane;
      o_lane_oe <= next_lane_oe;
    end
  end

  always_ff @(negedge i_spi_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_ack <= 1'b0;
    end else begin
      tx_ack <= next_tx_ack;
    end
  end

  //--------------------------------------------------------------
  // System domain: frame tracking, buffer, status
  //--------------------------------------------------------------
  st_t        st, next_st;
  logic [4:0] ss1, ss2, ss3, sf, next_sf;
  logic [9:0] frame_cnt, next_frame_cnt, page_lim;
  logic [8:0] pend, next_pend, tail, next_tail;
  logic       pend_v, next_pend_v, tail_v, next_tail_v;
  logic       cs_hi, cs_fall, rx_evt, accepted, drop, drain, pop;
  logic       next_tx_req, next_tx_ready, next_rx_valid, next_ovf;
  logic [7:0] next_tx_hold, next_rx_data;
  logic       next_rx_first, next_overrun, next_wpblk;
  logic [19:0] next_erase_base;

  assign next_sf  = (ss2 & ss3) | (sf & (ss2 ^ ss3));
  assign cs_hi    = sf[serial_flash_bus_pkg::SY_CS];
  assign cs_fall  = cs_hi && !next_sf[serial_flash_bus_pkg::SY_CS];
  assign rx_evt   = next_sf[serial_flash_bus_pkg::SY_RXT] !=
                    sf[serial_flash_bus_pkg::SY_RXT];
  assign accepted = rx_evt && st != ST_WAIT;
  assign page_lim = {6'h0, i_hdr_bytes} +
                    10'(serial_flash_bus_pkg::PAGE_BYTES);
  assign drop     = i_program_mode && frame_cnt >= page_lim;
  assign drain    = pend_v && !tail_v;
  assign pop      = o_rx_valid && i_rx_ready;

  always_comb begin
    next_st = st;
    case (st)
      ST_WAIT:   if (cs_fall) next_st = ST_FRAME;
      ST_IDLE:   if (!cs_hi) next_st = ST_FRAME;
      ST_FRAME: begin
        if (cs_hi) begin
          next_st = ST_IDLE;
        end else if (!sf[serial_flash_bus_pkg::SY_PAUSE] &&
                     !i_quad_io_enable_bit) begin
          next_st = ST_PAUSED;
        end
      end
      ST_PAUSED: begin
        if (sf[serial_flash_bus_pkg::SY_PAUSE] ||
            i_quad_io_enable_bit) begin
          next_st = cs_hi ? ST_IDLE : ST_FRAME;
        end
      end
      default:   next_st = ST_WAIT;
    endcase

    next_frame_cnt = frame_cnt;
    next_ovf       = o_page_overflow;
    next_overrun   = o_rx_overrun;
    if (st == ST_IDLE || st == ST_WAIT) begin
      next_frame_cnt = '0;
      next_ovf       = 1'b0;
      next_overrun   = 1'b0;
    end
    next_pend_v = pend_v && !drain;
    next_pend   = pend;
    // Sets come after the clears so a same-cycle event wins
    if (accepted) begin
      if (frame_cnt != serial_flash_bus_pkg::CNT_MAX) begin
        next_frame_cnt = frame_cnt + 10'h1;
      end
      if (drop) begin
        next_ovf = 1'b1;
      end else if (next_pend_v) begin
        next_overrun = 1'b1;
      end else begin
        next_pend_v = 1'b1;
        next_pend   = {frame_cnt == '0, rx_hold};
      end
    end

    next_rx_valid = o_rx_valid;
    next_rx_data  = o_rx_data;
    next_rx_first = o_rx_first;
    next_tail_v   = tail_v;
    next_tail     = tail;
    if (pop) begin
      if (tail_v) begin
        {next_rx_first, next_rx_data} = tail;
        next_tail_v = 1'b0;
      end else begin
        next_rx_valid = 1'b0;
      end
    end
    if (drain) begin
      if (!next_rx_valid) begin
        {next_rx_first, next_rx_data} = pend;
        next_rx_valid = 1'b1;
      end else begin
        next_tail   = pend;
        next_tail_v = 1'b1;
      end
    end

    next_tx_hold = tx_hold;
    next_tx_req  = tx_req;
    if (i_tx_valid && o_tx_ready) begin
      next_tx_hold = i_tx_data;
      next_tx_req  = ~tx_req;
    end
    next_tx_ready = next_tx_req == next_sf[serial_flash_bus_pkg::SY_TXA];

    next_wpblk = !sf[serial_flash_bus_pkg::SY_WP] &&
                 !i_quad_io_enable_bit;
    next_erase_base = i_erase_addr;
    case (serial_flash_bus_pkg::erase_kind_t'(i_erase_kind))
      serial_flash_bus_pkg::ERASE_SECTOR:
        next_erase_base[serial_flash_bus_pkg::SECTOR_LSB-1:0] = '0;
      serial_flash_bus_pkg::ERASE_BLOCK32:
        next_erase_base[serial_flash_bus_pkg::BLOCK32_LSB-1:0] = '0;
      serial_flash_bus_pkg::ERASE_BLOCK64:
        next_erase_base[serial_flash_bus_pkg::BLOCK64_LSB-1:0] = '0;
      default:
        next_erase_base = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ss1 <= serial_flash_bus_pkg::SY_IDLE;
      ss2 <= serial_flash_bus_pkg::SY_IDLE;
      ss3 <= serial_flash_bus_pkg::SY_IDLE;
      sf  <= serial_flash_bus_pkg::SY_IDLE;
      st  <= ST_WAIT;
      frame_cnt <= '0;
      pend   <= '0;
      pend_v <= 1'b0;
      tail   <= '0;
      tail_v <= 1'b0;
      tx_hold <= '0;
      tx_req  <= 1'b0;
      o_tx_ready <= 1'b1;
      o_rx_data  <= '0;
      o_rx_first <= 1'b0;
      o_rx_valid <= 1'b0;
      o_selected <= 1'b0;
      o_standby  <= 1'b0;
      o_paused   <= 1'b0;
      o_mode_refused       <= 1'b0;
      o_status_write_block <= 1'b0;
      o_array_hw_protect   <= 1'b0;
      o_page_overflow <= 1'b0;
      o_rx_overrun    <= 1'b0;
      o_erase_base    <= '0;
    end else begin
      ss1 <= {tx_ack, rx_tgl, i_lane[2], i_lane[3], i_cs_n};
      ss2 <= ss1;
      ss3 <= ss2;
      sf  <= next_sf;
      st  <= next_st;
      frame_cnt <= next_frame_cnt;
      pend   <= next_pend;
      pend_v <= next_pend_v;
      tail   <= next_tail;
      tail_v <= next_tail_v;
      tx_hold <= next_tx_hold;
      tx_req  <= next_tx_req;
      o_tx_ready <= next_tx_ready;
      o_rx_data  <= next_rx_data;
      o_rx_first <= next_rx_first;
      o_rx_valid <= next_rx_valid;
      o_selected <= !cs_hi;
      o_standby  <= cs_hi && !i_busy;
      o_paused   <= next_st == ST_PAUSED;
      o_mode_refused <= i_lane_mode == serial_flash_bus_pkg::LANE_QUAD &&
                        !i_quad_io_enable_bit;
      o_status_write_block <= next_wpblk;
      o_array_hw_protect   <= next_wpblk && (|i_status_lock_bits) &&
                              (|i_region_protect);
      o_page_overflow <= next_ovf;
      o_rx_overrun    <= next_overrun;
      o_erase_base    <= next_erase_base;
    end
  end

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_float; i_cs_n |-> o_lane_oe == '0; endproperty
  a_float: assert property (p_float)
    else $error("lanes driven while deselected");
  property p_standby; cs_hi && !i_busy |=> o_standby; endproperty
  a_standby: assert property (p_standby)
    else $error("no standby when deselected");
  property p_wait; st == ST_WAIT |=> !pend_v && !o_rx_valid; endproperty
  a_wait: assert property (p_wait)
    else $error("byte taken before first select");
  property p_refuse;
    i_lane_mode == serial_flash_bus_pkg::LANE_QUAD &&
    !i_quad_io_enable_bit |=> o_mode_refused;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("quad accepted without enable");
  property p_wp;
    !sf[serial_flash_bus_pkg::SY_WP] && !i_quad_io_enable_bit
      |=> o_status_write_block;
  endproperty
  a_wp: assert property (p_wp)
    else $error("write protect not applied");
  property p_quad_wp; i_quad_io_enable_bit |=> !o_status_write_block;
  endproperty
  a_quad_wp: assert property (p_quad_wp)
    else $error("write protect active in quad");
  property p_pause;
    st == ST_FRAME && !cs_hi && !i_quad_io_enable_bit &&
    !sf[serial_flash_bus_pkg::SY_PAUSE] |=> o_paused;
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause not entered");
  property p_quad_pause; i_quad_io_enable_bit |=> !o_paused; endproperty
  a_quad_pause: assert property (p_quad_pause)
    else $error("pause active in quad");
  property p_page; accepted && drop |=> o_page_overflow; endproperty
  a_page: assert property (p_page)
    else $error("page limit not flagged");
  property p_rx_hold;
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("stalled byte lost");

endmodule : serial_flash_bus_port

`default_nettype wire

// *** spi_host_model.sv ***
// Host controller model: drives serial clock, select and data lanes.
// Assumes the bench resolves each lane wire from the port's output enable alone.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic      [3:0] o_lane,
  input  wire logic [3:0] i_lane,
  input  wire logic       i_wp_n,
  input  wire logic       i_pause_n
);
  logic       cpol = 1'b0;
  logic [3:0] drv  = 4'h0;
  logic [3:0] en   = 4'h0;
  // Powers up selected, so a select edge is owed before use
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
  end
  // Released lanes 0 and 1 show the inverse of their last value; lanes 2 and 3 show write protect and pause
  always_comb begin
    o_lane = (en & drv) | (~en & ~drv);
    if (!en[2]) o_lane[2] = i_wp_n;
    if (!en[3]) o_lane[3] = i_pause_n;
  end
  task automatic frame_begin(input logic mode3);
    cpol   = mode3;
    o_sclk = mode3;
    #5;
    o_cs_n = 1'b0;
    #5;
  endtask : frame_begin
  task automatic xfer(input int w, input logic [7:0] tx,
                      output logic [7:0] rx, input int n);
    logic [3:0] mask;
    mask = 4'((1 << w) - 1);
    rx   = 8'h00;
    en   = mask;
    for (int s = 0; s < n; s++) begin
      o_sclk = 1'b0;
      for (int k = 0; k < w; k++) drv[k] = tx[8 - w + k];
      tx = tx << w;
      #3;
      o_sclk = 1'b1;
      if (w == 1) rx = {rx[6:0], i_lane[1]};
      else rx = (rx << w) | 8'(i_lane & mask);
      #3;
      if (!cpol) o_sclk = 1'b0;
    end
  endtask : xfer
  task automatic frame_end();
    #3;
    en = 4'h0;
    #2;
    o_cs_n = 1'b1;
    // Deselect must outlast the system side's three-flop filter
    #100;
  endtask : frame_end
endmodule : spi_host_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of the serial flash bus port with a host model.
// Assumes the package, the port and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_spi_clk, i_cs_n, wp_n = 1'b1, pause_n = 1'b1;
  logic [3:0]  i_lane, host_lane, o_lane, o_lane_oe, i_hdr_bytes = 4'h0;
  logic        i_quad_io_enable_bit = 1'b0, i_out_en = 1'b0, i_busy = 1'b0;
  logic [1:0]  i_lane_mode = 2'h0, i_status_lock_bits = 2'h0;
  logic [1:0]  i_erase_kind = 2'h0;
  logic [2:0]  i_region_protect = 3'h0;
  logic        i_program_mode = 1'b0, i_tx_valid = 1'b0, i_rx_ready = 1'b1;
  logic [19:0] i_erase_addr = 20'h00000, o_erase_base;
  logic [7:0]  i_tx_data = 8'h00, o_rx_data, rb, b;
  logic        o_tx_ready, o_rx_first, o_rx_valid, o_selected, o_standby;
  logic        o_paused, o_mode_refused, o_status_write_block;
  logic        o_array_hw_protect, o_page_overflow, o_rx_overrun;
  logic [8:0]  exp_q[$];
  int          fails = 0, checks_done = 0;

  always #10 i_sys_clk = ~i_sys_clk;
  always_comb
    for (int k = 0; k < 4; k++)
      i_lane[k] = (o_lane_oe[k] === 1'b1) ? o_lane[k] : host_lane[k];

  spi_host_model i_host (.o_sclk(i_spi_clk), .o_cs_n(i_cs_n),
    .o_lane(host_lane), .i_lane(i_lane), .i_wp_n(wp_n), .i_pause_n(pause_n));
  serial_flash_bus_port i_dut (.i_sys_clk, .i_rst, .i_spi_clk, .i_cs_n,
    .i_lane, .o_lane, .o_lane_oe, .i_quad_io_enable_bit, .i_lane_mode,
    .i_out_en, .i_busy, .i_status_lock_bits, .i_region_protect,
    .i_program_mode, .i_hdr_bytes, .i_erase_kind, .i_erase_addr,
    .o_erase_base, .i_tx_data, .i_tx_valid, .o_tx_ready, .o_rx_data,
    .o_rx_first, .o_rx_valid, .i_rx_ready, .o_selected, .o_standby,
    .o_paused, .o_mode_refused, .o_status_write_block,
    .o_array_hw_protect, .o_page_overflow, .o_rx_overrun);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  function automatic logic [19:0] base(input logic [1:0] k,
                                       input logic [19:0] a);
    case (k)
      2'h0:    base = a & ~20'h00FFF;
      2'h1:    base = a & ~20'h07FFF;
      2'h2:    base = a & ~20'h0FFFF;
      default: base = 20'h00000;
    endcase
  endfunction : base
  // Config crosses on link edges, which run only inside frames; four needed
  task automatic warm();
    repeat (4) begin
      i_host.frame_begin(1'b0);
      i_host.xfer(1, 8'h5A, rb, 1);
      i_host.frame_end();
    end
  endtask : warm
  task automatic bytes(input int w, input int n, input int nexp,
                       input logic first);
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      if (i < nexp) exp_q.push_back({first && i == 0, b});
      i_host.xfer(w, b, rb, 8 / w);
      #200;
    end
  endtask : bytes
  task automatic frame(input logic m3, input int w, input int n);
    i_host.frame_begin(m3);
    bytes(w, n, n, 1'b1);
    i_host.frame_end();
  endtask : frame
  task automatic wait_tx(input logic v);
    for (int i = 0; i < 50 && o_tx_ready !== v; i++) @(posedge i_sys_clk);
    chk("tx_ready", v, o_tx_ready);
  endtask : wait_tx

  // Receiver stalls at random; the buffer must lose nothing
  always @(posedge i_sys_clk) begin
    i_rx_ready <= ($urandom % 4) != 0;
    if (!i_rst && o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rx_extra", 20'hFFFFF, {o_rx_first, o_rx_data});
      else
        chk("rx_word", exp_q.pop_front(), {o_rx_first, o_rx_data});
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(73));
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1;
    chk("tx_ready_rst", 20'h1, o_tx_ready);
    i_host.xfer(1, 8'hC3, rb, 8);
    #300;
    i_host.frame_end();
    frame(1'b0, 1, 3);
    @(posedge i_sys_clk);
    i_lane_mode <= 2'h1;
    warm();
    frame(1'b1, 2, 3);
    @(posedge i_sys_clk);
    i_lane_mode <= 2'h2;
    warm();
    chk("mode_refused", 20'h1, o_mode_refused);
    frame(1'b0, 1, 2);
    @(posedge i_sys_clk);
    i_quad_io_enable_bit <= 1'b1;
    warm();
    chk("mode_refused", 20'h0, o_mode_refused);
    i_host.frame_begin(1'b0);
    pause_n = 1'b0;
    #200;
    chk("paused_qe", 20'h0, o_paused);
    pause_n = 1'b1;
    bytes(4, 4, 4, 1'b1);
    i_host.frame_end();
    @(posedge i_sys_clk);
    i_quad_io_enable_bit <= 1'b0;
    i_lane_mode <= 2'h0;
    warm();
    b = 8'($urandom);
    exp_q.push_back({1'b1, b});
    i_host.frame_begin(1'b0);
    i_host.xfer(1, b, rb, 4);
    pause_n = 1'b0;
    #200;
    chk("paused", 20'h1, o_paused);
    chk("selected", 20'h1, o_selected);
    chk("standby", 20'h0, o_standby);
    i_host.xfer(1, ~b, rb, 4);
    pause_n = 1'b1;
    #200;
    chk("paused", 20'h0, o_paused);
    i_host.xfer(1, b << 4, rb, 4);
    i_host.frame_end();
    i_host.frame_begin(1'b0);
    i_host.xfer(1, b, rb, 4);
    pause_n = 1'b0;
    #200;
    i_host.frame_end();
    #200;
    chk("paused_desel", 20'h1, o_paused);
    pause_n = 1'b1;
    #200;
    frame(1'b0, 1, 1);
    @(posedge i_sys_clk);
    i_out_en <= 1'b1;
    i_tx_data <= 8'($urandom);
    i_tx_valid <= 1'b1;
    wait_tx(1'b0);
    i_tx_valid <= 1'b0;
    warm();
    i_host.frame_begin(1'b0);
    bytes(1, 1, 1, 1'b1);
    exp_q.push_back({1'b0, 8'h00});
    i_host.xfer(1, 8'h00, rb, 8);
    chk("tx_byte", i_tx_data, rb);
    chk("lane_oe", 20'h2, o_lane_oe);
    i_host.frame_end();
    chk("lane_oe_idle", 20'h0, o_lane_oe);
    wait_tx(1'b1);
    for (int i = 0; i < 12; i++) begin
      @(posedge i_sys_clk);
      i_quad_io_enable_bit <= i[0];
      wp_n <= i[1];
      i_busy <= i[2];
      i_status_lock_bits <= 2'($urandom);
      i_region_protect <= 3'($urandom);
      i_erase_kind <= 2'(i);
      i_erase_addr <= 20'($urandom);
      repeat (6) @(posedge i_sys_clk);
      #1;
      chk("status_block", !i[1] && !i[0], o_status_write_block);
      chk("array_protect", !i[1] && !i[0] && |i_status_lock_bits
          && |i_region_protect, o_array_hw_protect);
      chk("standby", !i[2], o_standby);
      chk("erase_base", base(i_erase_kind, i_erase_addr), o_erase_base);
    end
    @(posedge i_sys_clk);
    wp_n <= 1'b1;
    i_program_mode <= 1'b1;
    i_hdr_bytes <= 4'h4;
    warm();
    i_host.frame_begin(1'b0);
    bytes(1, 260, 260, 1'b1);
    chk("page_overflow", 20'h0, o_page_overflow);
    bytes(1, 1, 0, 1'b0);
    #400;
    chk("page_overflow", 20'h1, o_page_overflow);
    chk("rx_overrun", 20'h0, o_rx_overrun);
    i_host.frame_end();
    for (int i = 0; i < 500 && exp_q.size() != 0; i++) @(posedge i_sys_clk);
    chk("rx_pending", 20'h0, 20'(exp_q.size()));
    print_verdict();
  end

  // Sequence needs about 76 us; allow about sixteen times that
  initial begin
    #1_200_000;
    fails++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
